/* File: src/snpep_pkg.sv */
// Constants, types and protection map for the serial NAND command block
// Function
// - Identifier page holds sixteen 32-byte records, second half the inverse of first.
// - A program load covers byte positions up to 2112, spare area included.
// - Command 06h sets the write latch; program without the latch is ignored.
// - Load data at or beyond column 2112 is discarded, never wrapped into the cache.
// - Raising chip select ends any program load or random load.
// - Execute is 10h plus 24-bit row; device stays busy for the program time.
// - Quad program uses 32h and 34h loads with data on four lines.
// - D8h erases one block after the latch is set; any address selects it.
// - Erase is rejected unless chip select rises exactly on a byte boundary.
// - Erase frame is opcode plus 24-bit address; erase starts at select rise.
// - Busy flag reads one during erase; completion clears it and the latch.
// - After power-up all protect levels are one, other protection bits zero.
// - Writing feature A0h with 1Fh updates the volatile protection bits.
// - Lock bit set, guard pin low, permanent clear: bits frozen, no quad mode.
// - Once the permanent bit is set, protection cannot be lowered until power-up.
// - Levels 000 none, 111 all, others fractions; flip and complement reshape.
// - Status bit 0 reads one while read, execute or erase is busy.
// - Status bit 3 flags program failure; cleared at the start of execute.
package snpep_pkg;

  localparam logic [7:0] OP_LATCH_SET  = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR  = 8'h04;
  localparam logic [7:0] OP_GET_FEAT   = 8'h0f;
  localparam logic [7:0] OP_SET_FEAT   = 8'h1f;
  localparam logic [7:0] OP_PAGE_READ  = 8'h13;
  localparam logic [7:0] OP_READ_CACHE = 8'h03;
  localparam logic [7:0] OP_LOAD       = 8'h02;
  localparam logic [7:0] OP_LOAD_RAND  = 8'h84;
  localparam logic [7:0] OP_LOAD_X4    = 8'h32;
  localparam logic [7:0] OP_RAND_X4    = 8'h34;
  localparam logic [7:0] OP_EXEC       = 8'h10;
  localparam logic [7:0] OP_ERASE      = 8'hd8;

  localparam logic [7:0] FA_PROTECT = 8'ha0;
  localparam logic [7:0] FA_SECURE  = 8'hb0;
  localparam logic [7:0] FA_STATUS  = 8'hc0;

  localparam int PR_LOCK    = 7;
  localparam int PR_LVL_LSB = 3;
  localparam int PR_FLIP    = 2;
  localparam int PR_CMP     = 1;
  localparam int PR_PERM    = 0;
  localparam int SC_PROT    = 7;
  localparam int SC_EN      = 6;
  localparam int SR_OIP     = 0;
  localparam int SR_WEL     = 1;
  localparam int SR_EFAIL   = 2;
  localparam int SR_PFAIL   = 3;
  localparam int IO_GUARD   = 2;

  localparam logic [2:0]  IDX_FEAT_OUT = 3'h2;
  localparam logic [2:0]  IDX_DATA     = 3'h3;
  localparam logic [2:0]  IDX_MAX      = 3'h4;
  localparam logic [2:0]  ADDR_BYTES   = 3'h3;
  localparam logic [2:0]  NADR_MAX     = 3'h7;
  localparam logic [11:0] PAGE_BYTES   = 12'h840;
  localparam logic [11:0] UID_BYTES    = 12'h200;
  localparam int          UID_HALF_BIT = 4;

  localparam int          BLK_LSB    = 6;
  localparam int          BLK_W      = 11;
  localparam logic [11:0] NUM_BLOCKS = 12'h800;
  localparam logic [11:0] BLK_ONE    = 12'h001;
  localparam logic [2:0]  LVL_NONE   = 3'h0;
  localparam logic [2:0]  LVL_HALF   = 3'h6;
  localparam logic [2:0]  LVL_ALL    = 3'h7;
  localparam int          LVL_SHIFT  = 4;

  localparam int CLK_PERIOD_NS = 5;
  localparam int PROG_TIME_US  = 600;
  localparam int ERASE_TIME_US = 3500;
  localparam int READ_TIME_US  = 25;
  localparam int PROG_CYC  = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int ERASE_CYC = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int READ_CYC  = READ_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int CNT_W     = 20;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_SKIP   = 4'h1,
    ST_SETF_A = 4'h2,
    ST_SETF_D = 4'h3,
    ST_LOAD_H = 4'h4,
    ST_LOAD_L = 4'h5,
    ST_LOAD_D = 4'h6,
    ST_ADDR   = 4'h7,
    ST_RDC_H  = 4'h8,
    ST_RDC_L  = 4'h9,
    ST_RDC_D  = 4'ha
  } snpep_state_t;

  typedef enum logic [1:0] {
    BK_NONE  = 2'h0,
    BK_PROG  = 2'h1,
    BK_ERASE = 2'h2,
    BK_READ  = 2'h3
  } snpep_busy_t;

  function automatic logic prot_locked(input logic [BLK_W-1:0] blk,
                                       input logic [2:0]       lvl,
                                       input logic             flip,
                                       input logic             cmp);
    logic [BLK_W:0] size;
    logic           base;
    size = BLK_ONE << (lvl + LVL_SHIFT);
    base = flip ? ({1'b0, blk} < size) : ({1'b0, blk} >= (NUM_BLOCKS - size));
    if (lvl == LVL_NONE) prot_locked = 1'b0;
    else if (lvl == LVL_ALL) prot_locked = 1'b1;
    else if (cmp && (lvl == LVL_HALF)) prot_locked = (blk == '0);
    else prot_locked = cmp ? ~base : base;
  endfunction : prot_locked

endpackage : snpep_pkg

/* File: src/snpep_link.sv */
// Serial-clock side: byte shifter, feature readout and output driver
`timescale 1ns/100ps
module snpep_link (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        rst_n,
  input  wire logic [3:0]  sio_i,
  input  wire logic        quad_ok,
  input  wire logic [23:0] feat_vec,
  input  wire logic [7:0]  tx_byte,
  output logic      [7:0]  rx_byte,
  output logic             rx_tgl,
  output logic             partial,
  output logic             so_o,
  output logic             so_oe
);
  import snpep_pkg::*;

  logic       frame_rst;
  logic [2:0] bit_r;
  logic [7:0] sr_r;
  logic [2:0] idx_r;
  logic [7:0] op_r;
  logic [7:0] fa_r;
  logic [7:0] out_r;
  logic       quad;
  logic [3:0] bit_sum;
  logic       done;
  logic [7:0] byte_in;
  logic [7:0] sel_fa;
  logic [7:0] feat_sel;

  // Select high clears frame state; the serial clock is idle then
  assign frame_rst = cs_n | ~rst_n;
  assign quad    = quad_ok && (idx_r >= IDX_DATA) &&
                   ((op_r == OP_LOAD_X4) || (op_r == OP_RAND_X4));
  assign bit_sum = {1'b0, bit_r} + (quad ? 4'h4 : 4'h1);
  assign done    = bit_sum[3];
  assign byte_in = quad ? {sr_r[3:0], sio_i} : {sr_r[6:0], sio_i[0]};
  assign sel_fa  = (idx_r == 3'h1) ? byte_in : fa_r;

  // Feature bytes are sampled here; they move slowly against a byte time
  always_comb begin
    case (sel_fa)
      FA_PROTECT: feat_sel = feat_vec[23:16];
      FA_SECURE:  feat_sel = feat_vec[15:8];
      FA_STATUS:  feat_sel = feat_vec[7:0];
      default:    feat_sel = 8'h00;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_r <= 3'h0;
      sr_r  <= 8'h00;
      idx_r <= 3'h0;
      op_r  <= 8'h00;
      fa_r  <= 8'h00;
      out_r <= 8'h00;
    end else begin
      bit_r <= bit_sum[2:0];
      sr_r  <= byte_in;
      if (done) begin
        if (idx_r != IDX_MAX) idx_r <= idx_r + 3'h1;
        if (idx_r == 3'h0) op_r <= byte_in;
        if (idx_r == 3'h1) fa_r <= byte_in;
        out_r <= ((op_r == OP_GET_FEAT) && (idx_r != 3'h0)) ? feat_sel : tx_byte;
      end
    end
  end

  // Held over the frame end so the core can judge the boundary
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      rx_tgl  <= 1'b0;
      partial <= 1'b0;
    end else begin
      partial <= (bit_sum[2:0] != 3'h0);
      if (done) begin
        rx_byte <= byte_in;
        rx_tgl  <= ~rx_tgl;
      end
    end
  end

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      so_o  <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so_o  <= out_r[~bit_r];
      so_oe <= ((op_r == OP_GET_FEAT) && (idx_r >= IDX_FEAT_OUT)) ||
               ((op_r == OP_READ_CACHE) && (idx_r >= IDX_MAX));
    end
  end

endmodule : snpep_link

/* File: src/snpep_core.sv */
// Top: command sequencer, feature registers, cache and busy timing
`timescale 1ns/100ps
module snpep_core #(
  parameter int           PROG_CNT  = snpep_pkg::PROG_CYC,
  parameter int           ERASE_CNT = snpep_pkg::ERASE_CYC,
  parameter int           READ_CNT  = snpep_pkg::READ_CYC,
  parameter logic [127:0] UID_SEED  = 128'h0123456789abcdeffedcba9876543210
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] sio_i,
  output logic            so_o,
  output logic            so_oe
);
  import snpep_pkg::*;

  localparam int          SY_CS    = 0;
  localparam int          SY_TGL   = 1;
  localparam int          SY_PART  = 2;
  localparam int          SY_WP    = 3;
  localparam logic [3:0]  SYNC_RST = 4'h9;
  localparam int          CNT_MAX  = (1 << CNT_W) - 1;
  localparam logic [CNT_W-1:0] PROG_LD  = CNT_W'(PROG_CNT);
  localparam logic [CNT_W-1:0] ERASE_LD = CNT_W'(ERASE_CNT);
  localparam logic [CNT_W-1:0] READ_LD  = CNT_W'(READ_CNT);
  localparam logic [CNT_W-1:0] CNT_ONE  = 20'h00001;

  if ((PROG_CNT < 1) || (PROG_CNT > CNT_MAX) || (ERASE_CNT < 1) ||
      (ERASE_CNT > CNT_MAX) || (READ_CNT > CNT_MAX) ||
      (READ_CNT <= int'(UID_BYTES))) begin : g_bad_cnt
    $error("busy counts out of range for the timer");
  end

  typedef struct packed {
    logic [3:0]       s0;
    logic [3:0]       s1;
    logic [3:0]       s2;
    logic [3:0]       filt;
    logic [3:0]       filt_d;
    snpep_state_t     st;
    logic [7:0]       op;
    logic [7:0]       fa;
    logic [7:0]       tx;
    logic [2:0]       nadr;
    logic [11:0]      col;
    logic [11:0]      ptr;
    logic [23:0]      row;
    logic             write_latch_flag;
    logic             operation_in_progress_flag;
    logic             efail;
    logic             pfail;
    logic [2:0]       level;
    logic             lock;
    logic             flip;
    logic             cmp;
    logic             perm;
    logic             otp_en;
    logic             otp_prot;
    snpep_busy_t      kind;
    logic [CNT_W-1:0] cnt;
  } snpep_core_state_t;

  snpep_core_state_t r;
  snpep_core_state_t n;

  logic [7:0]  cache_mem [PAGE_BYTES];
  logic        wr_en;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rx_byte;
  logic        rx_tgl;
  logic        part_l;
  logic [23:0] feat_vec;
  logic [7:0]  prot_b;
  logic [7:0]  sec_b;
  logic [7:0]  stat_b;
  logic        ev;
  logic        cs_rise;
  logic        pin_protect_mode;
  logic        frozen;
  logic        locked;
  logic        framed;
  logic        quad_load;
  logic [7:0]  uid_b;

  function automatic logic [7:0] rd_cache(input logic [11:0] a);
    rd_cache = (a < PAGE_BYTES) ? cache_mem[a] : 8'hff;
  endfunction : rd_cache

  snpep_link u_link (
    .sck      (sck),
    .cs_n     (cs_n),
    .rst_n    (rst_n),
    .sio_i    (sio_i),
    .quad_ok  (~pin_protect_mode),
    .feat_vec (feat_vec),
    .tx_byte  (r.tx),
    .rx_byte  (rx_byte),
    .rx_tgl   (rx_tgl),
    .partial  (part_l),
    .so_o     (so_o),
    .so_oe    (so_oe)
  );

  always_comb begin
    prot_b = 8'h00;
    prot_b[PR_LOCK] = r.lock;
    prot_b[PR_LVL_LSB +: 3] = r.level;
    prot_b[PR_FLIP] = r.flip;
    prot_b[PR_CMP] = r.cmp;
    prot_b[PR_PERM] = r.perm;
    sec_b = 8'h00;
    sec_b[SC_PROT] = r.otp_prot;
    sec_b[SC_EN] = r.otp_en;
    stat_b = 8'h00;
    stat_b[SR_OIP] = r.operation_in_progress_flag;
    stat_b[SR_WEL] = r.write_latch_flag;
    stat_b[SR_EFAIL] = r.efail;
    stat_b[SR_PFAIL] = r.pfail;
  end

  assign feat_vec = {prot_b, sec_b, stat_b};
  assign ev       = r.filt[SY_TGL] ^ r.filt_d[SY_TGL];
  assign cs_rise  = r.filt[SY_CS] & ~r.filt_d[SY_CS];
  assign pin_protect_mode      = r.lock && !r.filt[SY_WP] && !r.perm;
  assign frozen   = pin_protect_mode || r.perm;
  assign locked   = prot_locked(r.row[BLK_LSB +: BLK_W], r.level,
                                r.flip, r.cmp);
  // Whole opcode plus three address bytes, ending on a byte edge
  assign framed   = (r.st == ST_ADDR) && (r.nadr == ADDR_BYTES) &&
                    !r.filt[SY_PART];
  assign quad_load = (r.op == OP_LOAD_X4) || (r.op == OP_RAND_X4);
  assign uid_b    = UID_SEED[{r.ptr[3:0], 3'h0} +: 8];

  always_comb begin
    n = r;
    wr_en = 1'b0;
    wr_addr = r.col;
    wr_data = rx_byte;
    // Three stages; a change counts once the last two agree
    n.s0 = {sio_i[IO_GUARD], part_l, rx_tgl, cs_n};
    n.s1 = r.s0;
    n.s2 = r.s1;
    n.filt = ((r.s1 ~^ r.s2) & r.s2) | ((r.s1 ^ r.s2) & r.filt);
    n.filt_d = r.filt;

    if (r.cnt != '0) begin
      n.cnt = r.cnt - CNT_ONE;
      if ((r.kind == BK_READ) && r.otp_en && (r.row == 24'h0) &&
          (r.ptr < UID_BYTES)) begin
        // Second half of each record is the inverse of the first
        wr_en = 1'b1;
        wr_addr = r.ptr;
        wr_data = r.ptr[UID_HALF_BIT] ? ~uid_b : uid_b;
        n.ptr = r.ptr + 12'h001;
      end
      if (r.cnt == CNT_ONE) begin
        n.operation_in_progress_flag = 1'b0;
        if (r.kind != BK_READ) n.write_latch_flag = 1'b0;
      end
    end

    if (ev) begin
      case (r.st)
        ST_IDLE: begin
          n.op = rx_byte;
          n.nadr = 3'h0;
          n.st = ST_SKIP;
          // Only feature reads, status polling among them, are served while busy
          if (!r.operation_in_progress_flag) begin
            case (rx_byte)
              OP_LATCH_SET: n.write_latch_flag = 1'b1;
              OP_LATCH_CLR: n.write_latch_flag = 1'b0;
              OP_SET_FEAT:  n.st = ST_SETF_A;
              OP_LOAD, OP_LOAD_RAND, OP_LOAD_X4, OP_RAND_X4:
                n.st = ST_LOAD_H;
              OP_EXEC, OP_ERASE, OP_PAGE_READ: n.st = ST_ADDR;
              OP_READ_CACHE: n.st = ST_RDC_H;
              default: n.st = ST_SKIP;
            endcase
          end
        end
        ST_SETF_A: begin
          n.fa = rx_byte;
          n.st = ST_SETF_D;
        end
        ST_SETF_D: begin
          n.st = ST_SKIP;
          if ((r.fa == FA_PROTECT) && !frozen) begin
            n.lock = rx_byte[PR_LOCK];
            n.level = rx_byte[PR_LVL_LSB +: 3];
            n.flip = rx_byte[PR_FLIP];
            n.cmp = rx_byte[PR_CMP];
            n.perm = r.perm | rx_byte[PR_PERM];
          end
          if (r.fa == FA_SECURE) begin
            n.otp_en = rx_byte[SC_EN];
            n.otp_prot = r.otp_prot | rx_byte[SC_PROT];
          end
        end
        ST_LOAD_H: begin
          n.col = {rx_byte[3:0], r.col[7:0]};
          n.st = ST_LOAD_L;
        end
        ST_LOAD_L: begin
          n.col = {r.col[11:8], rx_byte};
          n.st = ST_LOAD_D;
        end
        ST_LOAD_D: begin
          // Column stops at the page end: no wrap into low bytes
          if (r.col < PAGE_BYTES) begin
            wr_en = !quad_load || !pin_protect_mode;
            wr_addr = r.col;
            wr_data = rx_byte;
            n.col = r.col + 12'h001;
          end
        end
        ST_ADDR: begin
          n.row = {r.row[15:0], rx_byte};
          if (r.nadr != NADR_MAX) n.nadr = r.nadr + 3'h1;
        end
        ST_RDC_H: begin
          n.col = {rx_byte[3:0], r.col[7:0]};
          n.st = ST_RDC_L;
        end
        ST_RDC_L: begin
          // Prefetch one byte ahead; the dummy byte covers the crossing
          n.tx = rd_cache({r.col[11:8], rx_byte});
          n.ptr = {r.col[11:8], rx_byte} + 12'h001;
          n.st = ST_RDC_D;
        end
        ST_RDC_D: begin
          n.tx = rd_cache(r.ptr);
          if (r.ptr < PAGE_BYTES) n.ptr = r.ptr + 12'h001;
        end
        ST_SKIP: n.st = ST_SKIP;
        default: n.st = ST_IDLE;
      endcase
    end

    if (cs_rise) begin
      n.st = ST_IDLE;
      if (framed) begin
        case (r.op)
          OP_EXEC: begin
            if (r.write_latch_flag) begin
              n.pfail = 1'b0;
              if (locked || (r.otp_en && r.otp_prot)) begin
                n.pfail = 1'b1;
                n.write_latch_flag = 1'b0;
              end else begin
                n.operation_in_progress_flag = 1'b1;
                n.kind = BK_PROG;
                n.cnt = PROG_LD;
              end
            end
          end
          OP_ERASE: begin
            if (r.write_latch_flag) begin
              n.efail = 1'b0;
              if (locked) begin
                n.efail = 1'b1;
                n.write_latch_flag = 1'b0;
              end else begin
                n.operation_in_progress_flag = 1'b1;
                n.kind = BK_ERASE;
                n.cnt = ERASE_LD;
              end
            end
          end
          OP_PAGE_READ: begin
            n.operation_in_progress_flag = 1'b1;
            n.kind = BK_READ;
            n.cnt = READ_LD;
            n.ptr = 12'h000;
          end
          default: n.operation_in_progress_flag = r.operation_in_progress_flag;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.s0 <= SYNC_RST;
      r.s1 <= SYNC_RST;
      r.s2 <= SYNC_RST;
      r.filt <= SYNC_RST;
      r.filt_d <= SYNC_RST;
      r.level <= LVL_ALL;
    end else begin
      r <= n;
    end
  end

  // Cache holds no reset; contents are undefined until loaded
  always_ff @(posedge clk) begin
    if (wr_en) cache_mem[wr_addr] <= wr_data;
  end

  a_latch_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    ev && (r.st == ST_IDLE) && !r.operation_in_progress_flag && (rx_byte == OP_LATCH_SET)
    |=> r.write_latch_flag)
    else $error("latch not set by 06h");

  a_exec_no_latch: assert property (
    @(posedge clk) disable iff (!rst_n)
    cs_rise && framed && (r.op == OP_EXEC) && !r.write_latch_flag
    |=> !r.operation_in_progress_flag && $stable(r.pfail))
    else $error("program ran without write latch");

  a_load_bound: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_en && (r.st == ST_LOAD_D) |-> (wr_addr < PAGE_BYTES))
    else $error("load wrote beyond page end");

  a_cs_ends_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    cs_rise && (r.st == ST_LOAD_D) |=> (r.st == ST_IDLE) [*2])
    else $error("load continued after select rise");

  a_prog_time: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(r.operation_in_progress_flag) && (r.kind == BK_PROG) |-> (r.cnt == PROG_LD) && !r.pfail)
    else $error("program busy time or fail clear wrong");

  a_erase_frame: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(r.operation_in_progress_flag) && (r.kind == BK_ERASE)
    |-> $past(framed) && $past(cs_rise) && $past(r.write_latch_flag))
    else $error("erase started off a byte boundary");

  a_erase_done: assert property (
    @(posedge clk) disable iff (!rst_n)
    $fell(r.operation_in_progress_flag) && (r.kind != BK_READ) |-> !r.write_latch_flag && (r.cnt == '0))
    else $error("erase end left latch or timer set");

  a_frozen_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    ev && (r.st == ST_SETF_D) && frozen
    |=> $stable(r.level) && $stable(r.flip) && $stable(r.cmp))
    else $error("protection changed while frozen");

  a_perm_keep: assert property (
    @(posedge clk) disable iff (!rst_n)
    r.perm |=> r.perm && $stable(r.level))
    else $error("permanent protection lowered");

  a_locked_erase: assert property (
    @(posedge clk) disable iff (!rst_n)
    cs_rise && framed && (r.op == OP_ERASE) && r.write_latch_flag && locked
    |=> r.efail && !r.operation_in_progress_flag && !r.write_latch_flag)
    else $error("erase of locked block not refused");

endmodule : snpep_core

/* File: verif/snpep_host.sv */
// Host model issuing command frames on the serial link
`timescale 1ns/100ps
module snpep_host (
  input  wire logic       clk,
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] sio,
  input  wire logic       so_o,
  input  wire logic       so_oe
);
  logic       guard;
  logic [7:0] last;
  event       got;

  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    sio = 4'h5;
    guard = 1'b1;
    last = 8'h00;
  end

  // Undriven output reads unknown, never a stale bit
  task automatic tick(input logic [3:0] v);
    sio = v;
    #16 sck = 1'b1;
    last = {last[6:0], (so_oe === 1'b1) ? so_o : 1'bx};
    #16 sck = 1'b0;
  endtask : tick

  // Spare lines 3 and 1 toggle each bit so no level is relied on; line 2 holds guard
  function automatic logic [3:0] x1(input logic b);
    return {~sio[3], guard, ~sio[1], b};
  endfunction : x1

  // Clock stands still outside frames
  task automatic frame(input logic [7:0] b[$], input int nrd = 0,
                       input int tail = 0, input int qf = 99,
                       input bit chk = 1'b0);
    @(negedge clk);
    cs_n = 1'b0;
    foreach (b[i]) begin
      if (i >= qf) begin
        tick(b[i][7:4]);
        tick(b[i][3:0]);
      end else begin
        for (int k = 7; k >= 0; k--) tick(x1(b[i][k]));
      end
    end
    for (int k = 0; k < tail; k++) tick(x1(1'b1));
    for (int n = 0; n < nrd; n++) begin
      for (int k = 0; k < 8; k++) tick(x1(1'b0));
      if (chk) -> got;
    end
    #16 cs_n = 1'b1;
    #40;
  endtask : frame
endmodule : snpep_host

/* File: verif/tb_top.sv */
// Self-checking bench for the serial NAND command block
`timescale 1ns/100ps
module tb_top;
  import snpep_pkg::*;
  localparam logic [127:0] SEED = 128'h5a3c96e10f1e2d3c4b5a69788796a5b4;
  logic       clk;
  logic       rst_n;
  logic       sck;
  logic       cs_n;
  logic [3:0] sio;
  logic       so_o;
  logic       so_oe;
  logic [7:0] exp_q[$];
  logic [7:0] pr;
  logic [7:0] dv[6];
  logic [7:0] uid[$];
  int         bad_count;
  int         n_checks;
  int         lvl;
  int         sz;
  int         blk;

  snpep_core #(.PROG_CNT(600), .ERASE_CNT(800), .READ_CNT(600),
    .UID_SEED(SEED)) DUT (.clk(clk), .rst_n(rst_n), .sck(sck),
    .cs_n(cs_n), .sio_i(sio), .so_o(so_o), .so_oe(so_oe));
  snpep_host host (.clk(clk), .sck(sck), .cs_n(cs_n), .sio(sio),
    .so_o(so_o), .so_oe(so_oe));

  always #2.5 clk = ~clk;

  task automatic chk8(input string nm, input logic [7:0] e, s);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk8

  // A byte read with no note queued is a mismatch, even if it reads unknown
  always @(host.got) begin
    if (exp_q.size() == 0) bad_count++;
    else chk8("read byte", exp_q.pop_front(), host.last);
  end

  task automatic rd(input logic [7:0] b[$], input logic [7:0] e[$]);
    foreach (e[i]) exp_q.push_back(e[i]);
    host.frame(b, e.size(), 0, 99, 1'b1);
  endtask : rd

  task automatic st(input logic [7:0] fa, input logic [7:0] e);
    rd('{OP_GET_FEAT, fa}, '{e});
  endtask : st

  task automatic setf(input logic [7:0] fa, input logic [7:0] d);
    host.frame('{OP_SET_FEAT, fa, d});
  endtask : setf

  // Bounded poll; only status reads go out while busy
  task automatic wait_rdy;
    int n;
    for (n = 0; n < 100; n++) begin
      host.frame('{OP_GET_FEAT, FA_STATUS}, 1);
      if (host.last[SR_OIP] === 1'b0) break;
    end
    if (n == 100) bad_count++;
  endtask : wait_rdy

  task automatic erase(input logic [23:0] r, input logic [7:0] base,
                       input bit lk);
    host.frame('{OP_LATCH_SET});
    host.frame('{OP_ERASE, r[23:16], r[15:8], r[7:0]});
    if (lk) begin
      st(FA_STATUS, base | 8'h04);
    end else begin
      st(FA_STATUS, base | 8'h03);
      wait_rdy();
      st(FA_STATUS, base);
    end
  endtask : erase

  function automatic bit lk_exp(int l, bit fl, bit cm, int b);
    bit up;
    up = fl ? (b < (1 << (l + 4))) : (b >= 2048 - (1 << (l + 4)));
    if (l == 0) return 1'b0;
    if (l == 7) return 1'b1;
    if (cm && l == 6) return b == 0;
    return cm ? !up : up;
  endfunction : lk_exp

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset

  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    bad_count++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    bad_count = 0;
    n_checks = 0;
    void'($urandom(91));
    do_reset();
    rd('{OP_GET_FEAT, FA_PROTECT}, '{8'h38});
    st(FA_SECURE, 8'h00);
    host.frame('{OP_EXEC, 8'h00, 8'h00, 8'h00});
    st(FA_STATUS, 8'h00);
    host.frame('{OP_LATCH_SET});
    st(FA_STATUS, 8'h02);
    // Cleared latch must also block an execute on a locked page
    host.frame('{OP_LATCH_CLR});
    host.frame('{OP_EXEC, 8'h00, 8'h00, 8'h00});
    st(FA_STATUS, 8'h00);
    for (int i = 0; i < 10; i++) begin
      lvl = $urandom % 8;
      pr = {2'b00, lvl[2:0], 1'($urandom), 1'($urandom), 1'b0};
      sz = 1 << (lvl + 4);
      blk = (($urandom % 2) ? 2048 - sz : sz) - $urandom % 2;
      blk = blk & 2047;
      setf(FA_PROTECT, pr);
      st(FA_PROTECT, pr);
      erase({7'h00, blk[10:0], 6'($urandom)}, 8'h00,
            lk_exp(lvl, pr[PR_FLIP], pr[PR_CMP], blk));
    end
    setf(FA_PROTECT, 8'h00);
    erase(24'h000145, 8'h00, 1'b0);
    foreach (dv[i]) dv[i] = 8'($urandom);
    host.frame('{OP_LATCH_SET});
    // Random load replaces the second byte of the plain load
    host.frame('{OP_LOAD, 8'h00, 8'h00, dv[0], ~dv[1]});
    host.frame('{OP_LOAD_RAND, 8'h00, 8'h01, dv[1]});
    host.frame('{OP_LOAD_X4, 8'h08, 8'h3d, ~dv[2], dv[5]},
               0, 0, 3);
    host.frame('{OP_RAND_X4, 8'h08, 8'h3e, dv[2], dv[3], dv[4], dv[5]},
               0, 0, 3);
    rd('{OP_READ_CACHE, 8'h00, 8'h00, 8'h00}, '{dv[0], dv[1]});
    rd('{OP_READ_CACHE, 8'h08, 8'h3d, 8'h00},
       '{~dv[2], dv[2], dv[3], 8'hff, 8'hff});
    // Single program of this page between erases
    host.frame('{OP_EXEC, 8'h00, 8'h01, 8'h40});
    st(FA_STATUS, 8'h03);
    wait_rdy();
    st(FA_STATUS, 8'h00);
    setf(FA_PROTECT, 8'h38);
    host.frame('{OP_LATCH_SET});
    host.frame('{OP_EXEC, 8'h00, 8'h01, 8'h40});
    st(FA_STATUS, 8'h08);
    setf(FA_PROTECT, 8'h00);
    host.frame('{OP_LATCH_SET});
    host.frame('{OP_ERASE, 8'h00, 8'h01, 8'h40}, 0, 4);
    st(FA_STATUS, 8'h0a);
    erase(24'h000140, 8'h08, 1'b0);
    setf(FA_SECURE, 8'h40);
    st(FA_SECURE, 8'h40);
    host.frame('{OP_PAGE_READ, 8'h00, 8'h00, 8'h00});
    wait_rdy();
    for (int i = 0; i < 64; i++) begin
      pr = SEED[8 * (i % 16) +: 8];
      uid.push_back((i % 32 < 16) ? pr : ~pr);
    end
    rd('{OP_READ_CACHE, 8'h00, 8'h00, 8'h00}, uid);
    setf(FA_SECURE, 8'h00);
    st(FA_SECURE, 8'h00);
    host.guard = 1'b0;
    setf(FA_PROTECT, 8'h80);
    setf(FA_PROTECT, 8'h38);
    st(FA_PROTECT, 8'h80);
    host.guard = 1'b1;
    setf(FA_PROTECT, 8'h09);
    setf(FA_PROTECT, 8'h00);
    st(FA_PROTECT, 8'h09);
    do_reset();
    st(FA_PROTECT, 8'h38);
    st(FA_STATUS, 8'h00);
    finish_test();
  end
endmodule : tb_top
